// *** hw/timer_pwm_pkg.sv ***
// Shared constants, types and decoders of the PWM waveform timer.
package timer_pwm_pkg;

	// ****************************************
	// Widths, offsets and field positions.
	// ****************************************
	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_COMPARE_A = 8'h04;
	localparam logic [7:0] OFF_COMPARE_B = 8'h08;
	localparam logic [7:0] OFF_CAPTURE_TOP = 8'h0C;
	localparam logic [7:0] OFF_COUNTER = 8'h10;
	localparam logic [7:0] OFF_FLAGS = 8'h14;
	localparam logic [7:0] OFF_PINS = 8'h18;
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_COM_A_LSB = 4;
	localparam int CTL_COM_B_LSB = 6;
	localparam int CTL_CS_LSB = 8;
	localparam int CTL_DIR_A_BIT = 11;
	localparam int CTL_DIR_B_BIT = 12;
	localparam int FLG_OVERFLOW = 0;
	localparam int FLG_COMPARE_A = 1;
	localparam int FLG_COMPARE_B = 2;
	localparam int FLG_CAPTURE = 3;

	// ****************************************
	// Reset values and counter limits.
	// ****************************************
	localparam logic [12:0] CONTROL_RESET = 13'h0000;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;

	// ****************************************
	// Waveform modes, output modes and clock selects.
	// ****************************************
	localparam logic [3:0] MODE_PC_8 = 4'h1;
	localparam logic [3:0] MODE_PC_9 = 4'h2;
	localparam logic [3:0] MODE_PC_10 = 4'h3;
	localparam logic [3:0] MODE_FAST_8 = 4'h5;
	localparam logic [3:0] MODE_FAST_9 = 4'h6;
	localparam logic [3:0] MODE_FAST_10 = 4'h7;
	localparam logic [3:0] MODE_PC_CAPT = 4'hA;
	localparam logic [3:0] MODE_PC_CMPA = 4'hB;
	localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
	localparam logic [3:0] MODE_FAST_CMPA = 4'hF;
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_NONINV = 2'h2;
	localparam logic [1:0] COM_INV = 2'h3;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [9:0] MASK_DIV1 = 10'h000;
	localparam logic [9:0] MASK_DIV8 = 10'h007;
	localparam logic [9:0] MASK_DIV64 = 10'h03F;
	localparam logic [9:0] MASK_DIV256 = 10'h0FF;
	localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

	// ****************************************
	// Types.
	// ****************************************
	typedef enum logic {DIR_UP, DIR_DOWN} dir_e;

	typedef struct packed {
		logic tick;
		logic single;
		logic dual;
		logic at_top;
		logic at_bottom;
		dir_e dir;
		logic [15:0] cnt;
	} count_state_s;

	typedef struct packed {
		logic [1:0] com;
		logic toggle_ok;
		logic [15:0] compare;
	} chan_ctl_s;

	// ****************************************
	// Mode decoders.
	// ****************************************
	function automatic logic is_single(input logic [3:0] mode);
		return mode inside {MODE_FAST_8, MODE_FAST_9, MODE_FAST_10, MODE_FAST_CAPT,
			MODE_FAST_CMPA};
	endfunction

	function automatic logic is_dual(input logic [3:0] mode);
		return mode inside {MODE_PC_8, MODE_PC_9, MODE_PC_10, MODE_PC_CAPT, MODE_PC_CMPA};
	endfunction

	function automatic logic [15:0] fixed_mask(input logic [3:0] mode);
		logic [15:0] m;
		m = TOP_MAX;
		if (mode == MODE_PC_8 || mode == MODE_FAST_8)
			m = TOP_8BIT;
		if (mode == MODE_PC_9 || mode == MODE_FAST_9)
			m = TOP_9BIT;
		if (mode == MODE_PC_10 || mode == MODE_FAST_10)
			m = TOP_10BIT;
		return m;
	endfunction

endpackage

// *** hw/timer_prescaler.sv ***
// Prescaler that turns the I/O clock into a one-cycle timer tick.
module timer_prescaler
	import timer_pwm_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Clock select and tick.
	input wire logic [2:0] clock_select,
	output logic tick
);

	logic [9:0] div_cnt;
	logic [9:0] next_div_cnt;
	logic [9:0] mask;

	always_comb
	begin
		unique case (clock_select)
			CS_DIV1: mask = MASK_DIV1;
			CS_DIV8: mask = MASK_DIV8;
			CS_DIV64: mask = MASK_DIV64;
			CS_DIV256: mask = MASK_DIV256;
			default: mask = MASK_DIV1024;
		endcase
		tick = (clock_select inside {CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024})
			&& ((div_cnt & mask) == mask); // [R3]
		next_div_cnt = (clock_select == CS_STOP) ? 10'h000 : div_cnt + 10'h001;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			div_cnt <= 10'h000;
		else
			div_cnt <= next_div_cnt;
	end

	property p_div8_period;
		@(posedge mclk) disable iff (!rst_n)
		(tick && clock_select == CS_DIV8 && $stable(clock_select))
			|=> (!tick || clock_select != CS_DIV8) [*7] ##1 (tick || clock_select != CS_DIV8);
	endproperty
	a_div8_period: assert property (p_div8_period) else $error("Divide-by-8 tick spacing wrong."); // [R3]

endmodule

// *** hw/compare_unit.sv ***
// Waveform generator of one compare channel.
module compare_unit
	import timer_pwm_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Counter state and channel settings.
	input wire count_state_s cs,
	input wire chan_ctl_s ch,
	// Waveform level and match pulse.
	output logic wave,
	output logic match
);

	logic next_wave;
	logic counting_up;

	always_comb
	begin
		match = cs.tick && cs.cnt == ch.compare;
		counting_up = cs.at_bottom || (!cs.at_top && cs.dir == DIR_UP);
		next_wave = wave;
		if (cs.tick && ch.com == COM_TOGGLE && ch.toggle_ok)
		begin
			if (match)
				next_wave = !wave; // [R6] [R16]
		end
		else if (cs.tick && ch.com[1] && cs.single)
		begin
			if (cs.at_top)
				next_wave = !ch.com[0]; // [R1] [R5]
			else if (match)
				next_wave = ch.com[0]; // [R1] [R4]
		end
		else if (cs.tick && ch.com[1] && cs.dual && match)
		begin
			next_wave = counting_up ? ch.com[0] : !ch.com[0]; // [R10] [R15]
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			wave <= 1'b0;
		else
			wave <= next_wave; // [R22]
	end

	// ****************************************
	// Checks.
	// ****************************************
	property p_fast_set_at_wrap;
		@(posedge mclk) disable iff (!rst_n)
		(cs.tick && cs.single && cs.at_top && ch.com == COM_NONINV && !ch.toggle_ok) |=> wave;
	endproperty
	a_fast_set_at_wrap: assert property (p_fast_set_at_wrap) else $error("No set at wrap."); // [R1]

	property p_dual_clear_up;
		@(posedge mclk) disable iff (!rst_n)
		(match && cs.dual && cs.dir == DIR_UP && !cs.at_top && ch.com == COM_NONINV) |=> !wave;
	endproperty
	a_dual_clear_up: assert property (p_dual_clear_up) else $error("No clear on up match."); // [R10]

	property p_toggle;
		@(posedge mclk) disable iff (!rst_n)
		(match && ch.toggle_ok && ch.com == COM_TOGGLE) |=> wave != $past(wave);
	endproperty
	a_toggle: assert property (p_toggle) else $error("No toggle on match."); // [R6] [R16]

endmodule

// *** hw/timer_pwm.sv ***
// Top of the 16-bit timer with fast and phase correct PWM and an APB slave.
//
// Function
// [R1] Fast PWM output mode 2 non-inverted, 3 inverted; match and wrap flip level.
// [R2] Waveform reaches the pin only while its direction bit selects output.
// [R3] Fast PWM period is prescale times TOP plus one clocks.
// [R4] Fast PWM with compare zero gives a one-tick spike each period.
// [R5] Fast PWM with compare equal TOP gives a constant level.
// [R6] Mode 15 channel A output mode 1 toggles on every match.
// [R7] Modes 1, 2, 3, 10, 11 count up to TOP and back down.
// [R8] Phase correct TOP is 0x00FF, 0x01FF, 0x03FF, capture or compare A.
// [R9] Counter holds TOP one tick then counts down.
// [R10] Dual slope: clear on up match, set on down match, inverted reverses.
// [R11] Phase correct sets the overflow flag at BOTTOM.
// [R12] Phase correct loads buffered compares at TOP and flags the TOP source.
// [R13] With fixed TOP, compare writes clear bits above the resolution.
// [R14] Software keeps TOP at or above every compare value.
// [R15] Phase correct compare BOTTOM gives low, TOP gives high, inverted opposite.
// [R16] Mode 11 channel A output mode 1 toggles for 50 percent duty.
// [R17] Software changing TOP at run time should prefer the other dual mode.
// [R18] Phase correct period is twice prescale times TOP clocks.
// [R19] Variable TOP supports 2 to 16 bits of resolution.
// [R20] Fast PWM counts to TOP then clears to BOTTOM next tick.
// [R21] Fast PWM sets overflow at TOP, plus the TOP source flag.
// [R22] Counter, matching and outputs advance only on the prescaled tick.
module timer_pwm
	import timer_pwm_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Compare output pins.
	output logic compare_output_a,
	output logic compare_output_a_oe,
	output logic compare_output_b,
	output logic compare_output_b_oe
);

	// ****************************************
	// Reset release.
	// ****************************************
	logic rst_meta, rst_n;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ****************************************
	// Registers and counter.
	// ****************************************
	logic [12:0] control;
	logic [15:0] compare_buf_a;
	logic [15:0] compare_buf_b;
	logic [15:0] compare_value_a;
	logic [15:0] compare_value_b;
	logic [15:0] capture_top_value;
	logic [15:0] counter_value;
	dir_e dir;
	logic [3:0] flags;
	logic [12:0] next_control;
	logic [15:0] next_compare_buf_a;
	logic [15:0] next_compare_buf_b;
	logic [15:0] next_compare_value_a;
	logic [15:0] next_compare_value_b;
	logic [15:0] next_capture_top_value;
	logic [15:0] next_counter_value;
	dir_e next_dir;
	logic [3:0] next_flags;
	logic [31:0] next_prdata;
	logic [3:0] waveform_gen_mode;
	logic [1:0] compare_output_mode_a, compare_output_mode_b;
	logic pin_direction_a, pin_direction_b;
	logic tick;
	logic [15:0] top;
	logic wr, setup, mapped;
	logic wave_a, wave_b, match_a, match_b;
	count_state_s cs;
	chan_ctl_s ch_a, ch_b;

	assign waveform_gen_mode = control[CTL_MODE_LSB +: 4];
	assign compare_output_mode_a = control[CTL_COM_A_LSB +: 2];
	assign compare_output_mode_b = control[CTL_COM_B_LSB +: 2];
	assign pin_direction_a = control[CTL_DIR_A_BIT];
	assign pin_direction_b = control[CTL_DIR_B_BIT];

	timer_prescaler u_prescaler (
		.mclk(mclk),
		.rst_n(rst_n),
		.clock_select(control[CTL_CS_LSB +: 3]),
		.tick(tick)
	);

	always_comb
	begin
		unique case (waveform_gen_mode)
			MODE_PC_8, MODE_FAST_8: top = TOP_8BIT; // [R8] [R20]
			MODE_PC_9, MODE_FAST_9: top = TOP_9BIT;
			MODE_PC_10, MODE_FAST_10: top = TOP_10BIT;
			MODE_PC_CAPT, MODE_FAST_CAPT: top = capture_top_value; // [R19]
			MODE_PC_CMPA, MODE_FAST_CMPA: top = compare_value_a;
			default: top = TOP_MAX;
		endcase
		cs.tick = tick;
		cs.single = is_single(waveform_gen_mode);
		cs.dual = is_dual(waveform_gen_mode); // [R7]
		cs.at_top = counter_value == top;
		cs.at_bottom = counter_value == BOTTOM;
		cs.dir = dir;
		cs.cnt = counter_value;
		ch_a.com = compare_output_mode_a;
		ch_a.toggle_ok = waveform_gen_mode == MODE_FAST_CMPA || waveform_gen_mode == MODE_PC_CMPA;
		ch_a.compare = compare_value_a;
		ch_b.com = compare_output_mode_b;
		ch_b.toggle_ok = 1'b0;
		ch_b.compare = compare_value_b;
	end

	compare_unit u_compare_a (
		.mclk(mclk),
		.rst_n(rst_n),
		.cs(cs),
		.ch(ch_a),
		.wave(wave_a),
		.match(match_a)
	);

	compare_unit u_compare_b (
		.mclk(mclk),
		.rst_n(rst_n),
		.cs(cs),
		.ch(ch_b),
		.wave(wave_b),
		.match(match_b)
	);

	// ****************************************
	// Next-state logic.
	// ****************************************
	always_comb
	begin
		wr = psel && penable && pwrite;
		setup = psel && !penable;
		mapped = paddr inside {OFF_CONTROL, OFF_COMPARE_A, OFF_COMPARE_B, OFF_CAPTURE_TOP,
			OFF_COUNTER, OFF_FLAGS, OFF_PINS};
		next_control = control;
		next_compare_buf_a = compare_buf_a;
		next_compare_buf_b = compare_buf_b;
		next_capture_top_value = capture_top_value;
		next_counter_value = counter_value;
		next_dir = dir;
		next_flags = flags;
		next_compare_value_a = compare_value_a;
		next_compare_value_b = compare_value_b;
		if (wr && paddr == OFF_CONTROL)
			next_control = pwdata[12:0];
		if (wr && paddr == OFF_COMPARE_A)
			next_compare_buf_a = pwdata[15:0] & fixed_mask(waveform_gen_mode); // [R13]
		if (wr && paddr == OFF_COMPARE_B)
			next_compare_buf_b = pwdata[15:0] & fixed_mask(waveform_gen_mode); // [R13]
		if (wr && paddr == OFF_CAPTURE_TOP)
			next_capture_top_value = pwdata[15:0];
		if (wr && paddr == OFF_FLAGS)
			next_flags = flags & ~pwdata[3:0];
		if (!cs.single && !cs.dual)
		begin
			next_compare_value_a = compare_buf_a;
			next_compare_value_b = compare_buf_b;
		end
		if (tick) // [R22]
		begin
			if (cs.single)
			begin
				next_counter_value = cs.at_top ? BOTTOM : counter_value + 16'h0001; // [R20]
				next_dir = DIR_UP;
			end
			else if (cs.dual && dir == DIR_UP)
			begin
				if (cs.at_top || counter_value > top)
				begin
					next_counter_value = counter_value - 16'h0001; // [R9] [R18]
					next_dir = DIR_DOWN;
				end
				else
					next_counter_value = counter_value + 16'h0001;
			end
			else if (cs.dual)
			begin
				if (cs.at_bottom)
				begin
					next_counter_value = counter_value + 16'h0001;
					next_dir = DIR_UP;
				end
				else
					next_counter_value = counter_value - 16'h0001;
			end
			else
				next_counter_value = counter_value + 16'h0001;
			if ((cs.single || cs.dual) && cs.at_top)
			begin
				next_compare_value_a = compare_buf_a; // [R12]
				next_compare_value_b = compare_buf_b;
				if (waveform_gen_mode inside {MODE_PC_CAPT, MODE_FAST_CAPT})
					next_flags[FLG_CAPTURE] = 1'b1; // [R12] [R21]
				if (waveform_gen_mode inside {MODE_PC_CMPA, MODE_FAST_CMPA})
					next_flags[FLG_COMPARE_A] = 1'b1;
			end
			if ((cs.single && cs.at_top) || (cs.dual && cs.at_bottom)
				|| (!cs.single && !cs.dual && counter_value == TOP_MAX))
				next_flags[FLG_OVERFLOW] = 1'b1; // [R11] [R21]
			if (match_a)
				next_flags[FLG_COMPARE_A] = 1'b1;
			if (match_b)
				next_flags[FLG_COMPARE_B] = 1'b1;
		end
		next_prdata = prdata;
		if (setup)
		begin
			unique case (paddr)
				OFF_CONTROL: next_prdata = {19'h00000, control};
				OFF_COMPARE_A: next_prdata = {16'h0000, compare_buf_a};
				OFF_COMPARE_B: next_prdata = {16'h0000, compare_buf_b};
				OFF_CAPTURE_TOP: next_prdata = {16'h0000, capture_top_value};
				OFF_COUNTER: next_prdata = {16'h0000, counter_value};
				OFF_FLAGS: next_prdata = {28'h0000000, flags};
				OFF_PINS: next_prdata = {29'h00000000, dir == DIR_DOWN, wave_b, wave_a};
				default: next_prdata = 32'h00000000;
			endcase
		end
		pready = psel && penable;
		pslverr = psel && penable && !mapped;
		compare_output_a = pin_direction_a && wave_a; // [R2]
		compare_output_a_oe = pin_direction_a;
		compare_output_b = pin_direction_b && wave_b; // [R2]
		compare_output_b_oe = pin_direction_b;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			control <= CONTROL_RESET;
			compare_buf_a <= VALUE_RESET;
			compare_buf_b <= VALUE_RESET;
			compare_value_a <= VALUE_RESET;
			compare_value_b <= VALUE_RESET;
			capture_top_value <= VALUE_RESET;
			counter_value <= VALUE_RESET;
			dir <= DIR_UP;
			flags <= FLAGS_RESET;
			prdata <= 32'h00000000;
		end
		else
		begin
			control <= next_control;
			compare_buf_a <= next_compare_buf_a;
			compare_buf_b <= next_compare_buf_b;
			compare_value_a <= next_compare_value_a;
			compare_value_b <= next_compare_value_b;
			capture_top_value <= next_capture_top_value;
			counter_value <= next_counter_value;
			dir <= next_dir;
			flags <= next_flags;
			prdata <= next_prdata;
		end
	end

	// ****************************************
	// Checks.
	// ****************************************
	sequence s_up_at_top;
		tick && cs.dual && cs.at_top && dir == DIR_UP;
	endsequence
	sequence s_step_down;
		dir == DIR_DOWN && counter_value == $past(counter_value) - 16'h0001;
	endsequence

	property p_fast_wrap;
		@(posedge mclk) disable iff (!rst_n)
		(tick && cs.single && cs.at_top) |=> counter_value == BOTTOM && flags[FLG_OVERFLOW];
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("Fast PWM wrap wrong."); // [R20] [R21]
	property p_pin_gate;
		@(posedge mclk) disable iff (!rst_n)
		compare_output_a == (pin_direction_a && wave_a) && compare_output_a_oe == pin_direction_a;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("Pin gating wrong."); // [R2]
	property p_top_hold;
		@(posedge mclk) disable iff (!rst_n)
		s_up_at_top |=> s_step_down;
	endproperty
	a_top_hold: assert property (p_top_hold) else $error("No turn after TOP."); // [R9]
	property p_dual_overflow;
		@(posedge mclk) disable iff (!rst_n)
		(tick && cs.dual && cs.at_bottom) |=> flags[FLG_OVERFLOW];
	endproperty
	a_dual_overflow: assert property (p_dual_overflow) else $error("Overflow missed."); // [R11]
	property p_load_at_top;
		@(posedge mclk) disable iff (!rst_n)
		(tick && cs.dual && cs.at_top) |=> compare_value_b == $past(compare_buf_b);
	endproperty
	a_load_at_top: assert property (p_load_at_top) else $error("Compare not loaded."); // [R12]
	property p_mask_write;
		@(posedge mclk) disable iff (!rst_n)
		(wr && paddr == OFF_COMPARE_A && waveform_gen_mode == MODE_PC_8)
			|=> compare_buf_a[15:8] == 8'h00;
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("Compare not masked."); // [R13]
	property p_fixed_top;
		@(posedge mclk) disable iff (!rst_n)
		(waveform_gen_mode == MODE_PC_9) |-> top == TOP_9BIT && cs.dual;
	endproperty
	a_fixed_top: assert property (p_fixed_top) else $error("TOP wrong."); // [R7] [R8]
	property p_tick_gate;
		@(posedge mclk) disable iff (!rst_n)
		!tick |=> $stable(counter_value) && $stable(wave_a) && $stable(wave_b);
	endproperty
	a_tick_gate: assert property (p_tick_gate) else $error("Moved without tick."); // [R22]

endmodule

// *** test/test_timer_pwm.sv ***
// Self-checking bench of the PWM waveform timer, driven over APB.
module test_timer_pwm
	import timer_pwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Signals.
	// ****************************************
	typedef struct
	{
		logic [31:0] value;
		logic [31:0] mask;
		logic err;
	} note_s;

	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic compare_output_a;
	logic compare_output_a_oe;
	logic compare_output_b;
	logic compare_output_b_oe;
	note_s note_q[$];
	note_s cur;
	logic [31:0] lfsr_state = 32'h981CB582;
	int miscompares = 0;
	int n_checks = 0;

	always #25 mclk = ~mclk;

	timer_pwm dut
	(
		.mclk(mclk),
		.rst_b(rst_b),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.compare_output_a(compare_output_a),
		.compare_output_a_oe(compare_output_a_oe),
		.compare_output_b(compare_output_b),
		.compare_output_b_oe(compare_output_b_oe)
	);

	// ****************************************
	// Checks and verdict.
	// ****************************************
	function automatic logic [31:0] rnd();
		lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
		return lfsr_state;
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_count(input string what, input int exp, input int got);
		n_checks++;
		if (got != exp)
		begin
			miscompares++;
			$display("BAD %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Takes the oldest note whenever a transfer completes.
	always @(posedge mclk)
	begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && note_q.size() > 0)
		begin
			cur = note_q.pop_front();
			check_word("pslverr", 32'(cur.err), 32'(pslverr));
			if (pwrite === 1'b0)
				check_word("prdata", cur.value, prdata & cur.mask);
		end
	end

	// ****************************************
	// Bus transfers.
	// ****************************************
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
		input logic [31:0] mask, input logic err);
		int n;
		n = 0;
		note_q.push_back('{data & mask, mask, err});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge mclk);
		end
		if (n == 20)
		begin
			miscompares++;
			$display("BAD pready expected 1 seen %b", pready);
			give_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data, 32'h00000000, 1'b0);
	endtask

	task automatic rd(input logic [7:0] addr, input logic [31:0] data, input logic [31:0] mask);
		apb(1'b0, addr, data, mask, 1'b0);
	endtask

	// ****************************************
	// Waveform scenarios.
	// ****************************************
	function automatic int expect_high(input bit fast, input bit tg, input logic [1:0] com,
		input int n, input int top, input int k, input int p);
		int h;
		if (tg)
			h = p / 2;
		else if (fast)
			h = (k == top) ? p : (k + 1) * n;
		else
			h = 2 * k * n;
		if (com == 2'h3)
			h = p - h;
		return h;
	endfunction

	task automatic measure(input int p, input int ea, input int eb, input logic da,
		input logic db);
		int ha;
		int hb;
		ha = 0;
		hb = 0;
		repeat (p)
		begin
			@(posedge mclk);
			ha += int'(compare_output_a === 1'b1);
			hb += int'(compare_output_b === 1'b1);
		end
		check_count("high_a", ea, ha);
		check_count("high_b", eb, hb);
		check_word("oe_a", 32'(da), 32'(compare_output_a_oe));
		check_word("oe_b", 32'(db), 32'(compare_output_b_oe));
	endtask

	task automatic run(input logic [3:0] md, input logic [2:0] cs, input int n,
		input logic [1:0] com, input int top, input int k, input logic da);
		bit fast;
		bit tg;
		bit atop;
		bit capt;
		logic [15:0] kk;
		logic [15:0] ka;
		logic [15:0] keep;
		logic [12:0] ctl;
		logic db;
		int p;
		fast = md[2];
		tg = (com == 2'h1);
		atop = (md == MODE_PC_CMPA || md == MODE_FAST_CMPA);
		capt = (md == MODE_PC_CAPT || md == MODE_FAST_CAPT);
		keep = (atop || capt) ? TOP_MAX : 16'(top);
		kk = (k < 0) ? 16'(1 + rnd() % 32'(top - 1)) : 16'(k);
		ka = atop ? 16'(top) : kk;
		db = da & ~tg;
		ctl = {db, da, cs, tg ? 2'h0 : com, com, md};
		p = fast ? n * (top + 1) : 2 * n * top;
		if (tg)
			p = 2 * p;
		if (capt)
			wr(OFF_CAPTURE_TOP, 32'(top));
		wr(OFF_CONTROL, 32'(ctl));
		wr(OFF_COMPARE_A, 32'(ka | (16'(rnd()) & ~keep)));
		wr(OFF_COMPARE_B, 32'(kk | (16'(rnd()) & ~keep)));
		rd(OFF_COMPARE_A, 32'(ka), 32'hFFFFFFFF);
		rd(OFF_COMPARE_B, 32'(kk), 32'hFFFFFFFF);
		rd(OFF_CONTROL, 32'(ctl), 32'hFFFFFFFF);
		repeat (2 * p) @(posedge mclk);
		measure(p, da ? expect_high(fast, tg, com, n, top, int'(ka), p) : 0,
			db ? expect_high(fast, 1'b0, com, n, top, int'(kk), p) : 0, da, db);
		wr(OFF_FLAGS, 32'h0000000F);
		repeat (p) @(posedge mclk);
		rd(OFF_FLAGS, {28'h0, capt, 3'h7}, 32'h0000000F);
		$display("mode %0h test done", md);
	endtask

	initial
	begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		for (int a = 0; a < 32; a += 4)
			apb(1'b0, 8'(a), 32'h00000000, 32'hFFFFFFFF, a == 28);
		apb(1'b1, 8'h1C, 32'h0000FFFF, 32'h00000000, 1'b1);
		wr(OFF_COMPARE_A, 32'h00000003);
		$display("reset and map test done");
		run(4'hB, 3'h1, 1, 2'h1, 3, 0, 1'b1);
		run(4'hF, 3'h1, 1, 2'h1, 3, 0, 1'b1);
		run(4'hF, 3'h4, 256, 2'h2, 3, -1, 1'b1);
		run(4'hF, 3'h5, 1024, 2'h3, 3, -1, 1'b1);
		run(4'hF, 3'h3, 64, 2'h1, 5, 0, 1'b1);
		run(4'hB, 3'h1, 1, 2'h2, 20, -1, 1'b1);
		run(4'hA, 3'h1, 1, 2'h3, 40, -1, 1'b1);
		run(4'hE, 3'h1, 1, 2'h2, 60, -1, 1'b1);
		run(4'h5, 3'h1, 1, 2'h2, 255, 0, 1'b1);
		run(4'h5, 3'h1, 1, 2'h3, 255, 255, 1'b1);
		run(4'h5, 3'h1, 1, 2'h2, 255, -1, 1'b0);
		run(4'h5, 3'h2, 8, 2'h3, 255, -1, 1'b1);
		run(4'h1, 3'h1, 1, 2'h2, 255, 0, 1'b1);
		run(4'h1, 3'h1, 1, 2'h3, 255, 255, 1'b1);
		run(4'h1, 3'h1, 1, 2'h2, 255, -1, 1'b1);
		run(4'h2, 3'h1, 1, 2'h3, 511, -1, 1'b1);
		run(4'h6, 3'h1, 1, 2'h2, 511, -1, 1'b1);
		run(4'h3, 3'h1, 1, 2'h2, 1023, -1, 1'b1);
		run(4'h7, 3'h1, 1, 2'h3, 1023, -1, 1'b1);
		give_verdict();
	end

endmodule
